// *** sss_seq.sv ***
/*
  sss_seq: operating-state sequencer of a fieldbus slave.
  Holds power-up, mailbox-only, inputs-only, full exchange, firmware-load.
  Assumes: one clock, synchronous reset, requests from the bus side logic
  on the same clock; field inputs arrive asynchronously and are synchronised.
*/
`timescale 1ns/100ps
`default_nettype none

module sss_seq
  import sss_pkg::*;
#(
  parameter int NIN = 4,
  parameter int WIDTH = 8,
  parameter int AW = 2,
  parameter logic [WIDTH-1:0] SAFE_VALUE = '0
)
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // state request from the master side
  input wire logic req_valid,
  input wire logic [2:0] req_state,
  input wire sss_cfg_t cfg,
  // watchdog control
  input wire logic wdog_disable,
  // mailbox protocol of the current message
  input wire logic [3:0] mbx_proto,
  // field inputs and master output data
  input wire logic [NIN*WIDTH-1:0] field_in,
  input wire logic [WIDTH-1:0] master_out,
  input wire logic [AW-1:0] snap_rd_addr,
  // status
  output sss_state_t state_q,
  output logic ack_q,
  output logic err_q,
  output logic [1:0] err_code_q,
  output sss_perm_t perm_q,
  output logic [WIDTH-1:0] phys_out_q,
  output logic [WIDTH-1:0] snap_rd_data
);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [NIN*WIDTH-1:0] fin_s1_q;
  logic [NIN*WIDTH-1:0] fin_s2_q;
  logic wd_s1_q;
  logic wd_s2_q;

  // two stages; the first is read only by the second
  always_ff @(posedge clock)
  begin
    fin_s1_q <= field_in;
    fin_s2_q <= fin_s1_q;
    wd_s1_q <= wdog_disable;
    wd_s2_q <= wd_s1_q;
  end

  // ****************************************
  // request decode
  // ****************************************
  typedef enum logic [1:0] {
    SSS_PH_IDLE = 2'h0,
    SSS_PH_COPY = 2'h1
  } sss_phase_t;

  sss_state_t state_d;
  sss_phase_t phase_q;
  logic [AW-1:0] copy_idx_q;
  logic wdog_en_q;

  wire logic idle = (phase_q == SSS_PH_IDLE);
  wire logic go_req = req_valid && idle;
  // upward moves are single steps; downward moves need no check
  wire logic to_pu = (req_state == SSS_REQ_POWER_UP);
  wire logic to_mbx = (req_state == SSS_REQ_MBX_ONLY);
  wire logic to_inp = (req_state == SSS_REQ_INPUTS);
  wire logic to_full = (req_state == SSS_REQ_FULL);
  wire logic to_fw = (req_state == SSS_REQ_FW_LOAD);
  wire logic from_pu = (state_q == SSS_POWER_UP);
  wire logic from_mbx = (state_q == SSS_MBX_ONLY);
  wire logic from_inp = (state_q == SSS_INPUTS);
  wire logic from_full = (state_q == SSS_FULL);
  wire logic up_mbx = to_mbx && from_pu;
  wire logic up_inp = to_inp && from_mbx;
  wire logic up_full = to_full && from_inp;
  wire logic up_fw = to_fw && from_pu;
  wire logic down = (to_pu) || (to_mbx && (from_inp || from_full)) || (to_inp && from_full);
  wire logic same = (req_state == state_q);
  wire logic mbx_chk = cfg.mbx_ok;
  wire logic pd_chk = cfg.pd_ok && (!cfg.dc_used || cfg.dc_ok);
  wire logic legal = up_mbx || up_inp || up_full || up_fw || down || same;
  wire logic chk_ok = up_mbx ? mbx_chk : up_inp ? pd_chk : 1'b1;
  wire logic copy_last = (copy_idx_q == AW'(NIN - 1));

  // next state; a failed check keeps the present state
  always_comb
  begin
    state_d = state_q;
    if (go_req && legal && chk_ok && !up_inp)
      state_d = sss_state_t'(req_state);
    else if (phase_q == SSS_PH_COPY && copy_last)
      state_d = SSS_INPUTS;
  end

  // ****************************************
  // sequencer
  // ****************************************
  // power-up after reset; inputs-only waits for the snapshot
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q <= SSS_POWER_UP;
      phase_q <= SSS_PH_IDLE;
      copy_idx_q <= '0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      err_code_q <= SSS_ERR_NONE;
    end
    else
    begin
      state_q <= state_d;
      ack_q <= 1'b0;
      case (phase_q)
        SSS_PH_IDLE:
        begin
          if (go_req)
          begin
            if (!legal)
            begin
              err_q <= 1'b1;
              err_code_q <= SSS_ERR_ILLEGAL;
            end
            else if (!chk_ok)
            begin
              err_q <= 1'b1;
              err_code_q <= SSS_ERR_CONFIG;
            end
            else if (up_inp)
            begin
              phase_q <= SSS_PH_COPY;
              copy_idx_q <= '0;
            end
            else
            begin
              ack_q <= 1'b1;
              err_q <= 1'b0;
              err_code_q <= SSS_ERR_NONE;
            end
          end
        end
        SSS_PH_COPY:
        begin
          copy_idx_q <= copy_idx_q + 1'b1;
          if (copy_last)
          begin
            phase_q <= SSS_PH_IDLE;
            ack_q <= 1'b1;
            err_q <= 1'b0;
            err_code_q <= SSS_ERR_NONE;
          end
        end
        default:
          phase_q <= SSS_PH_IDLE;
      endcase
    end
  end

  // ****************************************
  // input snapshot and refresh
  // ****************************************
  wire logic pd_live = (state_q == SSS_INPUTS) || (state_q == SSS_FULL);
  logic [AW-1:0] ref_idx_q;
  // copy phase walks all words; live states refresh one word a cycle
  wire logic [AW-1:0] wr_idx = (phase_q == SSS_PH_COPY) ? copy_idx_q : ref_idx_q;
  wire logic wr_en = (phase_q == SSS_PH_COPY) || pd_live;
  wire logic [WIDTH-1:0] wr_word = fin_s2_q[wr_idx*WIDTH +: WIDTH];

  // refresh pointer wraps over the input words
  always_ff @(posedge clock)
  begin
    if (srst)
      ref_idx_q <= '0;
    else if (pd_live)
      ref_idx_q <= (ref_idx_q == AW'(NIN - 1)) ? '0 : ref_idx_q + 1'b1;
  end

  sss_mem #(
    .WIDTH(WIDTH),
    .DEPTH(NIN),
    .AW(AW)
  ) u_mem (
    .clock(clock),
    .wr_en(wr_en),
    .wr_addr(wr_idx),
    .wr_data(wr_word),
    .rd_addr(snap_rd_addr),
    .rd_data(snap_rd_data)
  );

  // ****************************************
  // traffic permissions and outputs
  // ****************************************
  wire logic file_msg = (mbx_proto == SSS_PROTO_FILE);
  wire logic mbx_allow_d = (state_q != SSS_POWER_UP);
  wire logic pd_allow_d = pd_live;
  wire logic file_only_d = (state_q == SSS_FW_LOAD) && file_msg;
  // watchdog disable lets inputs-only drive outputs too
  wire logic drive_out = (state_q == SSS_FULL) || (from_inp && !wdog_en_q);

  // permissions and physical outputs
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      perm_q <= '0;
      phys_out_q <= SAFE_VALUE;
      wdog_en_q <= SSS_WDOG_RESET;
    end
    else
    begin
      wdog_en_q <= !wd_s2_q;
      perm_q.mbx_allow <= mbx_allow_d && ((state_q != SSS_FW_LOAD) || file_msg);
      perm_q.pd_allow <= pd_allow_d;
      perm_q.file_only <= file_only_d;
      phys_out_q <= drive_out ? master_out : SAFE_VALUE;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_reset_power_up;
    @(posedge clock) srst |=> (state_q == SSS_POWER_UP) && !perm_q.mbx_allow && !perm_q.pd_allow;
  endproperty
  a_reset_power_up: assert property (p_reset_power_up) else $error("reset did not enter power-up");

  property p_mbx_check;
    @(posedge clock) disable iff (srst)
      (go_req && up_mbx && !cfg.mbx_ok) |=> (state_q == SSS_POWER_UP) && err_q;
  endproperty
  a_mbx_check: assert property (p_mbx_check) else $error("bad mailbox config accepted");

  property p_mbx_only_perm;
    @(posedge clock) disable iff (srst)
      $past(state_q == SSS_MBX_ONLY) && !$past(srst) && !srst |-> !perm_q.pd_allow && perm_q.mbx_allow;
  endproperty
  a_mbx_only_perm: assert property (p_mbx_only_perm) else $error("mailbox-only permissions wrong");

  property p_pd_check;
    @(posedge clock) disable iff (srst)
      (go_req && up_inp && !pd_chk) |=> (state_q == SSS_MBX_ONLY) && err_code_q == SSS_ERR_CONFIG;
  endproperty
  a_pd_check: assert property (p_pd_check) else $error("bad process data config accepted");

  property p_copy_first;
    @(posedge clock) disable iff (srst)
      (go_req && up_inp && pd_chk) |=> (state_q == SSS_MBX_ONLY && !ack_q)[*2];
  endproperty
  a_copy_first: assert property (p_copy_first) else $error("ack before input copy");

  property p_safe_out;
    @(posedge clock) disable iff (srst)
      (state_q == SSS_INPUTS && wdog_en_q) |=> phys_out_q == SAFE_VALUE;
  endproperty
  a_safe_out: assert property (p_safe_out) else $error("outputs not safe in inputs-only");

  property p_full_drive;
    @(posedge clock) disable iff (srst)
      (state_q == SSS_FULL) |=> phys_out_q == $past(master_out);
  endproperty
  a_full_drive: assert property (p_full_drive) else $error("outputs not driven in full exchange");

  property p_fw_entry;
    @(posedge clock) disable iff (srst)
      (state_q != SSS_FW_LOAD) ##1 (state_q == SSS_FW_LOAD) |-> $past(state_q) == SSS_POWER_UP;
  endproperty
  a_fw_entry: assert property (p_fw_entry) else $error("firmware-load from wrong state");

  property p_fw_perm;
    @(posedge clock) disable iff (srst)
      (state_q == SSS_FW_LOAD && !file_msg) |=> !perm_q.mbx_allow && !perm_q.pd_allow;
  endproperty
  a_fw_perm: assert property (p_fw_perm) else $error("firmware-load let other traffic pass");

  property p_wdog_release;
    @(posedge clock) disable iff (srst)
      (state_q == SSS_INPUTS && !wdog_en_q) |=> phys_out_q == $past(master_out);
  endproperty
  a_wdog_release: assert property (p_wdog_release) else $error("watchdog off but outputs held");

  c_to_full: cover property (@(posedge clock) disable iff (srst) state_q == SSS_FULL);
  c_to_fw: cover property (@(posedge clock) disable iff (srst) state_q == SSS_FW_LOAD);
  c_cfg_err: cover property (@(posedge clock) disable iff (srst) err_code_q == SSS_ERR_CONFIG);

endmodule
`default_nettype wire

// *** sss_pkg.sv ***
/*
  sss_pkg: shared types and constants for the slave state sequencer.
  Assumes: included before sss_seq and sss_mem.
*/
package sss_pkg;

  // state encodings
  typedef enum logic [2:0] {
    SSS_POWER_UP  = 3'h0,
    SSS_MBX_ONLY  = 3'h1,
    SSS_INPUTS    = 3'h2,
    SSS_FULL      = 3'h3,
    SSS_FW_LOAD   = 3'h4
  } sss_state_t;

  // requested-state command codes match the state codes
  localparam logic [2:0] SSS_REQ_POWER_UP = 3'h0;
  localparam logic [2:0] SSS_REQ_MBX_ONLY = 3'h1;
  localparam logic [2:0] SSS_REQ_INPUTS   = 3'h2;
  localparam logic [2:0] SSS_REQ_FULL     = 3'h3;
  localparam logic [2:0] SSS_REQ_FW_LOAD  = 3'h4;

  // mailbox protocol code for file transfer
  localparam logic [3:0] SSS_PROTO_FILE = 4'h4;

  // buffer channel numbers
  localparam logic [3:0] SSS_MBX_CH_OUT = 4'h0;
  localparam logic [3:0] SSS_MBX_CH_IN  = 4'h1;
  localparam logic [3:0] SSS_PD_CH_FIRST = 4'h2;

  // error codes
  localparam logic [1:0] SSS_ERR_NONE    = 2'h0;
  localparam logic [1:0] SSS_ERR_CONFIG  = 2'h1;
  localparam logic [1:0] SSS_ERR_ILLEGAL = 2'h2;

  // default value of the output watchdog enable
  localparam logic SSS_WDOG_RESET = 1'b1;

  // configuration checks presented by the configuration logic
  typedef struct packed {
    logic mbx_ok;
    logic pd_ok;
    logic dc_used;
    logic dc_ok;
  } sss_cfg_t;

  // traffic permissions
  typedef struct packed {
    logic mbx_allow;
    logic pd_allow;
    logic file_only;
  } sss_perm_t;

endpackage

// *** sss_mem.sv ***
/*
  sss_mem: input snapshot memory, the dual_port_buffer input area.
  Assumes: single clock, synchronous write, registered read.
*/
`timescale 1ns/100ps
`default_nettype none

module sss_mem
  import sss_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW = 2
)
(
  // clock
  input wire logic clock,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // storage; no reset so it maps to ram
  always_ff @(posedge clock)
  begin
    if (wr_en)
      mem_q[wr_addr] <= wr_data;
    rd_data <= mem_q[rd_addr];
  end

endmodule
`default_nettype wire

// *** sss_master.sv ***
/*
  sss_master: bus master model facing the state sequencer.
  Assumes: same clock as the sequencer; the bench calls its tasks.
*/
`timescale 1ns/100ps
`default_nettype none

module sss_master
  import sss_pkg::*;
(
  // clock and answer
  input wire logic clock,
  input wire logic ack_q,
  // request side
  output logic req_valid,
  output logic [2:0] req_state,
  output sss_cfg_t cfg,
  // output data
  output logic [7:0] master_out
);
  // *****************************
  // request driver
  // *****************************

  // idle from time zero
  initial
  begin
    req_valid = 1'b0;
    req_state = 3'h7;
    cfg = '0;
    master_out = 8'h00;
  end

  // one pulse; lat is cycles to ack, 0 when refused
  task automatic go(input logic [2:0] s, input sss_cfg_t c, output logic [3:0] lat);
    @(posedge clock);
    req_valid <= 1'b1;
    req_state <= s;
    cfg <= c;
    @(posedge clock);
    req_valid <= 1'b0;
    req_state <= ~s; // stale code is an invalid state code unless s is 3 or more
    lat = 4'h0;
    for (int i = 1; i < 9 && lat == 4'h0; i++)
    begin
      @(negedge clock);
      if (ack_q === 1'b1)
        lat = 4'(i);
    end
    repeat (2) @(negedge clock);
  endtask

  // output data is valid before full is asked for
  task automatic put(input logic [7:0] d);
    @(posedge clock);
    master_out <= d;
  endtask
endmodule

`default_nettype wire

// *** sss_seq_test.sv ***
/*
  sss_seq_test: self-checking bench of the state sequencer.
  Assumes: sss_master stands in for the bus master.
*/
`timescale 1ns/100ps
`default_nettype none

module sss_seq_test
  import sss_pkg::*;
;
  // *****************************
  // signals and instances
  // *****************************
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic wdog_disable = 1'b0;
  logic [3:0] mbx_proto = 4'h0;
  logic [31:0] field_in = 32'h44332211;
  logic [1:0] snap_rd_addr = 2'h0;
  logic req_valid;
  logic [2:0] req_state;
  sss_cfg_t cfg;
  logic [7:0] master_out;
  sss_state_t state_q;
  logic ack_q;
  logic err_q;
  logic [1:0] err_code_q;
  sss_perm_t perm_q;
  logic [7:0] phys_out_q;
  logic [7:0] snap_rd_data;
  logic [3:0] lat;
  int bad_count = 0;
  int n_checks = 0;

  always #12.5 clock = ~clock;

  sss_seq dut_u (.clock(clock), .srst(srst), .req_valid(req_valid), .req_state(req_state),
    .cfg(cfg), .wdog_disable(wdog_disable), .mbx_proto(mbx_proto), .field_in(field_in),
    .master_out(master_out), .snap_rd_addr(snap_rd_addr), .state_q(state_q), .ack_q(ack_q),
    .err_q(err_q), .err_code_q(err_code_q), .perm_q(perm_q), .phys_out_q(phys_out_q),
    .snap_rd_data(snap_rd_data));

  sss_master master_u (.clock(clock), .ack_q(ack_q), .req_valid(req_valid),
    .req_state(req_state), .cfg(cfg), .master_out(master_out));

  // *****************************
  // shared tasks
  // *****************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request, then state and error outcome
  task automatic req(input logic [2:0] s, input logic [3:0] c, input logic [2:0] st,
    input logic [1:0] code);
    master_u.go(s, sss_cfg_t'(c), lat);
    chk(8'(state_q), 8'(st));
    chk(8'(err_code_q), 8'(code));
    chk(8'(err_q), 8'(code != 2'h0));
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // *****************************
  // scenarios
  // *****************************
  task automatic t_refuse;
    chk(8'(state_q), 8'h00);
    chk(8'(perm_q), 8'h00);
    chk(phys_out_q, 8'h00);
    req(3'h1, 4'h7, 3'h0, 2'h1);
    req(3'h2, 4'hF, 3'h0, 2'h2);
    chk(8'(perm_q), 8'h00);
    $display("refuse test done");
  endtask

  task automatic t_boot;
    req(3'h4, 4'hF, 3'h4, 2'h0);
    @(posedge clock) mbx_proto <= SSS_PROTO_FILE;
    wait_n(3);
    chk(8'(perm_q.mbx_allow), 8'h01);
    chk(8'(perm_q.pd_allow), 8'h00);
    chk(8'(perm_q.file_only), 8'h01);
    @(posedge clock) mbx_proto <= 4'h3;
    wait_n(3);
    chk(8'(perm_q.mbx_allow), 8'h00);
    req(3'h2, 4'hF, 3'h4, 2'h2);
    req(3'h0, 4'hF, 3'h0, 2'h0);
    $display("boot test done");
  endtask

  task automatic t_preop;
    req(3'h1, 4'hF, 3'h1, 2'h0);
    chk(8'(lat), 8'h01);
    chk(8'(perm_q), 8'h04);
    req(3'h4, 4'hF, 3'h1, 2'h2);
    req(3'h2, 4'hB, 3'h1, 2'h1);
    req(3'h2, 4'hE, 3'h1, 2'h1);
    chk(8'(perm_q), 8'h04);
    $display("mailbox-only test done");
  endtask

  // copy before ack, then live refresh and safe outputs
  task automatic t_safeop;
    // word 3 is refreshed last, so right after the ack only the copy can have filled it
    @(posedge clock) snap_rd_addr <= 2'h3;
    req(3'h2, 4'hF, 3'h2, 2'h0);
    chk(8'(lat), 8'h05);
    chk(snap_rd_data, field_in[31:24]);
    chk(8'(perm_q), 8'h06);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock) snap_rd_addr <= 2'(i);
      wait_n(2);
      chk(snap_rd_data, field_in[i*8 +: 8]);
    end
    @(posedge clock) field_in[23:16] <= 8'h99;
    @(posedge clock) snap_rd_addr <= 2'h2;
    wait_n(12);
    chk(snap_rd_data, 8'h99);
    master_u.put(8'hA5);
    wait_n(3);
    chk(phys_out_q, 8'h00);
    @(posedge clock) wdog_disable <= 1'b1;
    wait_n(6);
    chk(phys_out_q, 8'hA5);
    @(posedge clock) wdog_disable <= 1'b0;
    wait_n(6);
    chk(phys_out_q, 8'h00);
    $display("inputs-only test done");
  endtask

  task automatic t_op;
    master_u.put(8'h3C);
    req(3'h3, 4'hF, 3'h3, 2'h0);
    chk(phys_out_q, 8'h3C);
    chk(8'(perm_q), 8'h06);
    master_u.put(8'h5A);
    wait_n(3);
    chk(phys_out_q, 8'h5A);
    req(3'h3, 4'hF, 3'h3, 2'h0);
    req(3'h1, 4'hF, 3'h1, 2'h0);
    chk(phys_out_q, 8'h00);
    req(3'h0, 4'hF, 3'h0, 2'h0);
    chk(8'(perm_q), 8'h00);
    // mid-run reset from mailbox-only must fall back to power-up
    req(3'h1, 4'hF, 3'h1, 2'h0);
    @(posedge clock) srst <= 1'b1;
    @(posedge clock) srst <= 1'b0;
    wait_n(2);
    chk(8'(state_q), 8'h00);
    chk(8'(perm_q), 8'h00);
    chk(8'(err_q), 8'h00);
    $display("full exchange test done");
  endtask

  // *****************************
  // main sequence and watchdog
  // *****************************
  initial
  begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    wait_n(1);
    t_refuse();
    t_boot();
    t_preop();
    t_safeop();
    t_op();
    end_of_test();
  end

  // tests need well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    bad_count++;
    end_of_test();
  end
endmodule

`default_nettype wire
